// ===== adc_scan_pkg.sv
// Constants and carrier types shared by the scan sequencer and its conversion timer
// How it works
// - Scan mode converts the selected channels one after another, four channels at most.
// - Conversion starts when the start bit becomes 1, set by software, the pulse timer or a pin.
// - The group select picks the first channel: 00 gives channel 0, 01 channel 4, 10 channel 8.
// - Each finished result is written to the data register of the channel just converted.
// - After the last selected channel the end flag is set, and with irq enable an interrupt rises.
// - After a full pass the group restarts at its first channel while the start bit stays set.
// - Clearing the start bit stops conversion.
// - Start delay follows clock select: 18-33, 10-17, 6-9 or 4-5 states, slowest first.
// - Sampling is 127, 63, 31 or 15 states; conversion 515-530, 259-266, 131-134 or 67-68.
package adc_scan_pkg;
   localparam int NUM_CHANNELS  = 12;
   localparam int CHAN_W        = 4;
   localparam int RESULT_W      = 10;
   localparam int GROUP_MAX     = 4;
   localparam int TCOUNT_W      = 10;
   // Timing in states, slowest clock select (00) first; minimum figures are used
   localparam logic [TCOUNT_W-1:0] START_DELAY_00 = 10'h012;
   localparam logic [TCOUNT_W-1:0] START_DELAY_01 = 10'h00A;
   localparam logic [TCOUNT_W-1:0] START_DELAY_10 = 10'h006;
   localparam logic [TCOUNT_W-1:0] START_DELAY_11 = 10'h004;
   localparam logic [TCOUNT_W-1:0] SAMPLE_00      = 10'h07F;
   localparam logic [TCOUNT_W-1:0] SAMPLE_01      = 10'h03F;
   localparam logic [TCOUNT_W-1:0] SAMPLE_10      = 10'h01F;
   localparam logic [TCOUNT_W-1:0] SAMPLE_11      = 10'h00F;
   localparam logic [TCOUNT_W-1:0] CONV_TIME_00   = 10'h203;
   localparam logic [TCOUNT_W-1:0] CONV_TIME_01   = 10'h103;
   localparam logic [TCOUNT_W-1:0] CONV_TIME_10   = 10'h083;
   localparam logic [TCOUNT_W-1:0] CONV_TIME_11   = 10'h043;
   localparam logic [1:0]  GROUP_RESERVED = 2'h3;
   localparam logic        START_RESET    = 1'h0;
   localparam logic        FLAG_RESET     = 1'h0;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_LAUNCH = 2'b01,
      ST_RUN    = 2'b10
   } seq_state_t;

   typedef enum logic [1:0] {
      TM_IDLE   = 2'b00,
      TM_DELAY  = 2'b01,
      TM_SAMPLE = 2'b10,
      TM_CONV   = 2'b11
   } timer_state_t;

   typedef struct packed {
      logic       scan_mode;
      logic       group_select_high;
      logic       group_select_low;
      logic [1:0] channel_count;
      logic       clock_select_high;
      logic       clock_select_low;
      logic       conversion_end_irq_enable;
      logic       timer_trigger_enable;
      logic       external_trigger_enable;
   } adc_config_t;
endpackage : adc_scan_pkg

// ===== adc_conversion_timer.sv
// Per-channel conversion timer: start delay, sampling window and conversion end
`timescale 1ns/10ps
module adc_conversion_timer (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       launch,
   input  wire logic       abort,
   input  wire logic [1:0] clock_select,
   output logic            sampling,
   output logic            busy,
   output logic            done
);
   adc_scan_pkg::timer_state_t            state_q, state_d;
   logic [adc_scan_pkg::TCOUNT_W-1:0]     count_q, count_d;
   logic [adc_scan_pkg::TCOUNT_W-1:0]     delay_n, sample_n, conv_n;

   always_comb begin
      case (clock_select)
         2'h0: begin
            delay_n  = adc_scan_pkg::START_DELAY_00;
            sample_n = adc_scan_pkg::SAMPLE_00;
            conv_n   = adc_scan_pkg::CONV_TIME_00;
         end
         2'h1: begin
            delay_n  = adc_scan_pkg::START_DELAY_01;
            sample_n = adc_scan_pkg::SAMPLE_01;
            conv_n   = adc_scan_pkg::CONV_TIME_01;
         end
         2'h2: begin
            delay_n  = adc_scan_pkg::START_DELAY_10;
            sample_n = adc_scan_pkg::SAMPLE_10;
            conv_n   = adc_scan_pkg::CONV_TIME_10;
         end
         default: begin
            delay_n  = adc_scan_pkg::START_DELAY_11;
            sample_n = adc_scan_pkg::SAMPLE_11;
            conv_n   = adc_scan_pkg::CONV_TIME_11;
         end
      endcase
   end

   // Count restarts at each phase; conversion phase holds the rest of the total time
   always_comb begin
      state_d = state_q;
      count_d = count_q + 10'h001;
      done    = 1'b0;
      case (state_q)
         adc_scan_pkg::TM_IDLE: begin
            count_d = 10'h001;
            if (launch) begin
               state_d = adc_scan_pkg::TM_DELAY;
            end
         end
         adc_scan_pkg::TM_DELAY: begin
            if (count_q >= delay_n) begin
               state_d = adc_scan_pkg::TM_SAMPLE;
               count_d = 10'h001;
            end
         end
         adc_scan_pkg::TM_SAMPLE: begin
            if (count_q >= sample_n) begin
               state_d = adc_scan_pkg::TM_CONV;
               count_d = 10'h001;
            end
         end
         adc_scan_pkg::TM_CONV: begin
            if (count_q >= conv_n - delay_n - sample_n) begin
               state_d = adc_scan_pkg::TM_IDLE;
               done    = 1'b1;
            end
         end
         default: state_d = adc_scan_pkg::TM_IDLE;
      endcase
      if (abort) begin
         state_d = adc_scan_pkg::TM_IDLE;
         done    = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= adc_scan_pkg::TM_IDLE;
         count_q <= 10'h000;
      end else begin
         state_q <= state_d;
         count_q <= count_d;
      end
   end

   assign sampling = (state_q == adc_scan_pkg::TM_SAMPLE);
   assign busy     = (state_q != adc_scan_pkg::TM_IDLE);
endmodule : adc_conversion_timer

// ===== adc_scan_sequencer.sv
// Scan and single mode sequencer: start sources, channel order, result registers, end flag
`timescale 1ns/10ps
module adc_scan_sequencer #(
   parameter int NUM_CHANNELS = adc_scan_pkg::NUM_CHANNELS,
   parameter int RESULT_W     = adc_scan_pkg::RESULT_W
) (
   input  wire logic                         clock,
   input  wire logic                         rst,
   input  wire adc_scan_pkg::adc_config_t    config_in,
   input  wire logic                         software_start,
   input  wire logic                         software_stop,
   input  wire logic                         pulse_timer_unit_trigger,
   input  wire logic                         external_trigger_pin,
   input  wire logic                         end_flag_clear,
   input  wire logic [RESULT_W-1:0]          core_result,
   output logic                              conversion_start_bit,
   output logic                              conversion_end_flag,
   output logic                              conversion_end_interrupt,
   output logic [adc_scan_pkg::CHAN_W-1:0]   analog_channel,
   output logic                              sample_hold,
   output logic                              converter_busy,
   output logic [NUM_CHANNELS*RESULT_W-1:0]  result_regs
);
   adc_scan_pkg::seq_state_t             state_q, state_d;
   logic                                 start_q, start_d;
   logic                                 flag_q, flag_d;
   logic [adc_scan_pkg::CHAN_W-1:0]      chan_q, chan_d;
   logic [2:0]                           ext_sync_q;
   logic                                 ext_level_q, ext_level_d;
   logic                                 ext_rise;
   logic                                 start_set;
   logic                                 launch;
   logic                                 done;
   logic                                 sampling;
   logic                                 timer_busy;
   logic                                 store;
   logic [1:0]                           group;
   logic [adc_scan_pkg::CHAN_W-1:0]      first_chan;
   logic [adc_scan_pkg::CHAN_W-1:0]      last_chan;
   logic                                 at_last;

   // Pin passes three flops; the level moves only once the last two agree
   always_comb begin
      ext_level_d = ext_level_q;
      if (ext_sync_q[1] == ext_sync_q[2]) begin
         ext_level_d = ext_sync_q[2];
      end
   end
   assign ext_rise = ext_level_d & ~ext_level_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_sync_q  <= 3'h0;
         ext_level_q <= 1'b0;
      end else begin
         ext_sync_q  <= {ext_sync_q[1:0], external_trigger_pin};
         ext_level_q <= ext_level_d;
      end
   end

   assign start_set = software_start
                    | (pulse_timer_unit_trigger & config_in.timer_trigger_enable)
                    | (ext_rise & config_in.external_trigger_enable);

   // Reserved group code falls back to the lowest group rather than leaving the range
   assign group      = {config_in.group_select_high, config_in.group_select_low};
   assign first_chan = (group == adc_scan_pkg::GROUP_RESERVED) ? 4'h0
                                                               : {group, 2'b00};
   // Single mode converts one channel; scan mode up to four in a row
   assign last_chan  = first_chan + {2'b00, config_in.channel_count};
   assign at_last    = !config_in.scan_mode || (chan_q == last_chan);

   always_comb begin
      state_d = state_q;
      start_d = start_q;
      flag_d  = flag_q;
      chan_d  = chan_q;
      launch  = 1'b0;
      store   = 1'b0;
      if (end_flag_clear) begin
         flag_d = 1'b0;
      end
      case (state_q)
         adc_scan_pkg::ST_IDLE: begin
            if (start_q) begin
               chan_d  = config_in.scan_mode ? first_chan : last_chan;
               state_d = adc_scan_pkg::ST_LAUNCH;
            end
         end
         adc_scan_pkg::ST_LAUNCH: begin
            launch  = 1'b1;
            state_d = adc_scan_pkg::ST_RUN;
         end
         adc_scan_pkg::ST_RUN: begin
            if (done) begin
               store = 1'b1;
               if (at_last) begin
                  flag_d = 1'b1;
                  if (config_in.scan_mode) begin
                     chan_d  = first_chan;
                     state_d = adc_scan_pkg::ST_LAUNCH;
                  end else begin
                     start_d = 1'b0;
                     state_d = adc_scan_pkg::ST_IDLE;
                  end
               end else begin
                  chan_d  = chan_q + 4'h1;
                  state_d = adc_scan_pkg::ST_LAUNCH;
               end
            end
         end
         default: state_d = adc_scan_pkg::ST_IDLE;
      endcase
      if (software_stop) begin
         start_d = 1'b0;
      end
      // A trigger in the same cycle as a stop wins
      if (start_set) begin
         start_d = 1'b1;
      end
      if (!start_q && state_q != adc_scan_pkg::ST_IDLE) begin
         state_d = adc_scan_pkg::ST_IDLE;
         launch  = 1'b0;
         store   = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= adc_scan_pkg::ST_IDLE;
         start_q <= adc_scan_pkg::START_RESET;
         flag_q  <= adc_scan_pkg::FLAG_RESET;
         chan_q  <= 4'h0;
      end else begin
         state_q <= state_d;
         start_q <= start_d;
         flag_q  <= flag_d;
         chan_q  <= chan_d;
      end
   end

   adc_conversion_timer u_timer (
      .clock        (clock),
      .rst          (rst),
      .launch       (launch),
      .abort        (!start_q),
      .clock_select ({config_in.clock_select_high, config_in.clock_select_low}),
      .sampling     (sampling),
      .busy         (timer_busy),
      .done         (done)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_result
         logic [RESULT_W-1:0] data_q, data_d;
         always_comb begin
            data_d = data_q;
            if (store && chan_q == gi[adc_scan_pkg::CHAN_W-1:0]) begin
               data_d = core_result;
            end
         end
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               data_q <= adc_scan_pkg::RESULT_RESET;
            end else begin
               data_q <= data_d;
            end
         end
         assign result_regs[gi*RESULT_W +: RESULT_W] = data_q;
      end
   endgenerate

   assign conversion_start_bit     = start_q;
   assign conversion_end_flag      = flag_q;
   assign conversion_end_interrupt = flag_q & config_in.conversion_end_irq_enable;
   assign analog_channel           = chan_q;
   assign sample_hold              = sampling;
   assign converter_busy           = timer_busy;
endmodule : adc_scan_sequencer

// ===== adc_scan_sequencer_assertions.sv
// Concurrent checks on the scan sequencer ports
`timescale 1ns/10ps
module adc_scan_sequencer_assertions #(
   parameter int NUM_CHANNELS = adc_scan_pkg::NUM_CHANNELS,
   parameter int RESULT_W     = adc_scan_pkg::RESULT_W
) (
   input wire logic                        clock,
   input wire logic                        rst,
   input wire adc_scan_pkg::adc_config_t   config_in,
   input wire logic                        software_start,
   input wire logic                        software_stop,
   input wire logic                        pulse_timer_unit_trigger,
   input wire logic                        external_trigger_pin,
   input wire logic                        end_flag_clear,
   input wire logic [RESULT_W-1:0]         core_result,
   input wire logic                        conversion_start_bit,
   input wire logic                        conversion_end_flag,
   input wire logic                        conversion_end_interrupt,
   input wire logic [adc_scan_pkg::CHAN_W-1:0] analog_channel,
   input wire logic                        sample_hold,
   input wire logic                        converter_busy,
   input wire logic [NUM_CHANNELS*RESULT_W-1:0] result_regs
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic fast = ({config_in.clock_select_high, config_in.clock_select_low} == 2'h3);
   sequence s_delay_fast;
      !sample_hold[*4] ##1 sample_hold;
   endsequence
   sequence s_sample_fast;
      sample_hold[*8] ##1 sample_hold[*7] ##1 !sample_hold;
   endsequence
   chk_start_set: assert property (software_start |=> conversion_start_bit)
      else $error("start pulse did not set the start bit");
   chk_stop_clear: assert property (
      software_stop && !software_start && !pulse_timer_unit_trigger
      && !config_in.external_trigger_enable |=> !conversion_start_bit ##[0:2] !converter_busy)
      else $error("stop did not halt conversion");
   chk_launch_busy: assert property ($rose(conversion_start_bit) |-> ##[1:3] converter_busy)
      else $error("conversion did not begin after start");
   chk_delay_fast: assert property (disable iff (rst || software_stop)
      $rose(converter_busy) && fast |-> s_delay_fast)
      else $error("start delay wrong");
   chk_sample_fast: assert property (disable iff (rst || software_stop)
      $rose(sample_hold) && fast |-> s_sample_fast)
      else $error("sampling window wrong");
   chk_group_range: assert property (converter_busy && config_in.scan_mode
      && {config_in.group_select_high, config_in.group_select_low} != 2'h3
      |-> analog_channel[3:2] == {config_in.group_select_high, config_in.group_select_low}
      && analog_channel[1:0] <= config_in.channel_count)
      else $error("channel outside selected group");
   chk_chan_step: assert property (config_in.scan_mode && $changed(analog_channel)
      && $past(conversion_start_bit) |-> analog_channel == $past(analog_channel) + 4'h1
      || analog_channel[1:0] == 2'h0)
      else $error("channel order broken");
   chk_flag_cause: assert property ($rose(conversion_end_flag) |-> $past(converter_busy))
      else $error("end flag set without conversion");
   chk_flag_clear: assert property ($fell(conversion_end_flag) |-> $past(end_flag_clear))
      else $error("end flag dropped by itself");
   chk_irq_level: assert property (conversion_end_interrupt
      == (conversion_end_flag && config_in.conversion_end_irq_enable))
      else $error("interrupt does not follow flag and enable");
endmodule : adc_scan_sequencer_assertions

bind adc_scan_sequencer adc_scan_sequencer_assertions #(.NUM_CHANNELS(NUM_CHANNELS),
   .RESULT_W(RESULT_W)) u_adc_scan_sequencer_assertions (.clock(clock), .rst(rst),
   .config_in(config_in), .software_start(software_start), .software_stop(software_stop),
   .pulse_timer_unit_trigger(pulse_timer_unit_trigger),
   .external_trigger_pin(external_trigger_pin), .end_flag_clear(end_flag_clear),
   .core_result(core_result), .conversion_start_bit(conversion_start_bit),
   .conversion_end_flag(conversion_end_flag),
   .conversion_end_interrupt(conversion_end_interrupt), .analog_channel(analog_channel),
   .sample_hold(sample_hold), .converter_busy(converter_busy), .result_regs(result_regs));

// ===== adc_far_side.sv
// Far side model: analog inputs seen through the core result, and the pulse timer unit
`timescale 1ns/10ps
module adc_far_side (
   input  wire logic                           clock,
   input  wire logic                           rst,
   input  wire logic [adc_scan_pkg::CHAN_W-1:0] analog_channel,
   input  wire logic                           fire,
   output logic [adc_scan_pkg::RESULT_W-1:0]    core_result,
   output logic                                timer_trigger
);
   logic fire_q;
   // Each input holds a level naming its channel, so a misrouted store shows up
   assign core_result = {6'h2D, analog_channel};
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fire_q        <= 1'h0;
         timer_trigger <= 1'h0;
      end else begin
         fire_q        <= fire;
         timer_trigger <= fire && !fire_q;
      end
   end
endmodule : adc_far_side

// ===== test_adc_scan_sequencer.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/10ps
module test_adc_scan_sequencer;
   logic                      clock = 1'b0;
   logic                      rst = 1'b1;
   adc_scan_pkg::adc_config_t cfg = '0;
   logic                      software_start = 1'b0;
   logic                      software_stop = 1'b0;
   logic                      fire = 1'b0;
   logic                      external_trigger_pin = 1'b0;
   logic                      end_flag_clear = 1'b0;
   logic [9:0]                core_result;
   logic                      timer_trigger, start_bit, flag, irq, sample_hold, busy;
   logic [3:0]                channel;
   logic [119:0]              result_regs;
   int                        mismatches = 0;
   int                        samples_checked = 0;
   adc_far_side u_adc_far_side (.clock(clock), .rst(rst), .analog_channel(channel),
      .fire(fire), .core_result(core_result), .timer_trigger(timer_trigger));
   adc_scan_sequencer u_adc_scan_sequencer (.clock(clock), .rst(rst), .config_in(cfg),
      .software_start(software_start), .software_stop(software_stop),
      .pulse_timer_unit_trigger(timer_trigger), .external_trigger_pin(external_trigger_pin),
      .end_flag_clear(end_flag_clear), .core_result(core_result),
      .conversion_start_bit(start_bit), .conversion_end_flag(flag),
      .conversion_end_interrupt(irq), .analog_channel(channel), .sample_hold(sample_hold),
      .converter_busy(busy), .result_regs(result_regs));
   always #4 clock = ~clock;
   task automatic end_of_test();
      $display("Checked %0d values, %0d mismatches", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [9:0] res(input int ch);
      return result_regs[ch*10 +: 10];
   endfunction : res
   function automatic logic [9:0] exp_res(input logic [3:0] ch);
      return {6'h2D, ch};
   endfunction : exp_res
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic start();
      @(posedge clock) software_start <= 1'b1;
      @(posedge clock) software_start <= 1'b0;
      // The start bit updates at this edge, so look only once it has settled
      #1;
   endtask : start
   task automatic wait_flag(input int n);
      for (int i = 0; i < n; i++) begin
         step(1);
         if (flag === 1'b1) return;
      end
      mismatches++;
      $display("Timeout waiting for end flag");
      end_of_test();
   endtask : wait_flag
   task automatic stop_all();
      @(posedge clock) software_stop <= 1'b1;
      end_flag_clear <= 1'b1;
      @(posedge clock) software_stop <= 1'b0;
      end_flag_clear <= 1'b0;
      step(3);
      check(busy, 1'b0);
      check(start_bit, 1'b0);
   endtask : stop_all
   task automatic t_single();
      @(posedge clock) cfg <= '{scan_mode: 1'b0, group_select_high: 1'b1, channel_count: 2'h2,
         clock_select_high: 1'b1, clock_select_low: 1'b1, default: 1'b0};
      start();
      step(5);
      check(sample_hold, 1'b0);
      step(1);
      check(sample_hold, 1'b1);
      step(14);
      check(sample_hold, 1'b1);
      step(1);
      check(sample_hold, 1'b0);
      wait_flag(200);
      step(2);
      check(res(10), exp_res(4'hA));
      check(res(9), 10'h000);
      check(start_bit, 1'b0);
      stop_all();
      $display("Single mode test done");
   endtask : t_single
   task automatic t_scan();
      @(posedge clock) cfg <= '{scan_mode: 1'b1, channel_count: 2'h1, clock_select_high: 1'b1,
         clock_select_low: 1'b1, conversion_end_irq_enable: 1'b1, default: 1'b0};
      start();
      check(start_bit, 1'b1);
      wait_flag(200);
      check(res(0), exp_res(4'h0));
      check(res(1), exp_res(4'h1));
      check(res(2), 10'h000);
      check(irq, 1'b1);
      @(posedge clock) end_flag_clear <= 1'b1;
      @(posedge clock) end_flag_clear <= 1'b0;
      step(1);
      check(flag, 1'b0);
      check(start_bit, 1'b1);
      wait_flag(200);
      check(channel, 4'h0);
      // The timer rests one cycle between channels, so busy returns one edge later
      step(1);
      check(busy, 1'b1);
      @(posedge clock) cfg.conversion_end_irq_enable <= 1'b0;
      step(1);
      check(flag, 1'b1);
      check(irq, 1'b0);
      stop_all();
      $display("Scan test done");
   endtask : t_scan
   task automatic t_groups();
      for (int g = 1; g < 3; g++) begin
         @(posedge clock) cfg <= '{scan_mode: 1'b1, group_select_high: g[1],
            group_select_low: g[0], channel_count: 2'h3, clock_select_high: 1'b1,
            clock_select_low: 1'b1, default: 1'b0};
         start();
         wait_flag(400);
         for (int k = 0; k < 4; k++) check(res(4*g+k), exp_res(4'(4*g+k)));
         stop_all();
      end
      $display("Group test done");
   endtask : t_groups
   task automatic t_abort();
      // Reserved group code and a slower clock select, both unused by the earlier tests
      @(posedge clock) cfg.group_select_low <= 1'b1;
      cfg.group_select_high <= 1'b1;
      cfg.channel_count <= 2'h0;
      cfg.clock_select_low <= 1'b0;
      start();
      step(30);
      check(channel, 4'h0);
      check(sample_hold, 1'b1);
      stop_all();
      step(80);
      check(flag, 1'b0);
      $display("Abort test done");
   endtask : t_abort
   task automatic t_triggers();
      @(posedge clock) fire <= 1'b1;
      @(posedge clock) fire <= 1'b0;
      step(3);
      check(start_bit, 1'b0);
      @(posedge clock) cfg.timer_trigger_enable <= 1'b1;
      @(posedge clock) fire <= 1'b1;
      @(posedge clock) fire <= 1'b0;
      step(3);
      check(start_bit, 1'b1);
      @(posedge clock) cfg.timer_trigger_enable <= 1'b0;
      stop_all();
      @(posedge clock) cfg.external_trigger_enable <= 1'b1;
      @(posedge clock) external_trigger_pin <= 1'b1;
      step(10);
      check(start_bit, 1'b1);
      @(posedge clock) external_trigger_pin <= 1'b0;
      cfg.external_trigger_enable <= 1'b0;
      stop_all();
      $display("Trigger test done");
   endtask : t_triggers
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      step(1);
      check(start_bit, 1'b0);
      check(flag, 1'b0);
      check(result_regs === '0, 1'b1);
      t_single();
      t_scan();
      t_groups();
      t_abort();
      t_triggers();
      end_of_test();
   end
endmodule : test_adc_scan_sequencer
